// [design/ulf_line_format.sv]
/*
  Line format and baud generation for an asynchronous serial port:
  AXI4-Lite registers for character format and divisor, parity and
  stop period for the transmitter, parity and first-stop checks for
  the receiver, and a 16x baud tick.
  Assumes the shift datapaths sit outside and use the tick and the
  per-character strobes below.
// Behaviour
// - With parity enabled, parity bit sits between last data bit and stop bit.
// - Stop select 0 gives exactly one stop bit for any length.
// - Stop select 1 with five-bit characters gives one and a half stop bits.
// - Stop select 1 with six to eight bits gives two stop bits.
// - Receiver checks only the first stop bit.
// - Length field 00..11 selects five to eight data bits both directions.
// - Baud generator divides input clock by divisor giving sixteen times bit rate.
// - Any divisor from 2 to 65535 is accepted.
// - Divisor held in two byte latches forming one 16-bit value.
// - Writing either divisor byte reloads the baud counter at once.
// - Even select makes data plus parity ones even; cleared makes them odd.
// - Stick parity off means normal odd or even parity.
*/
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ulf_line_format (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Format to shift datapaths
  output logic tick_16x_o,
  output logic [1:0] char_len_o,
  output logic parity_en_o,
  // Transmit side
  input wire logic tx_load_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_parity_o,
  output logic [5:0] tx_stop_ticks_o,
  // Receive side
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  input wire logic rx_stop_i,
  output logic rx_par_err_o,
  output logic rx_frm_err_o
);
  typedef struct packed {
    logic [1:0] len;
    logic stop_sel;
    logic par_en;
    logic par_even;
    logic stick;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic div_load;
    logic aw_got;
    logic [4:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic tx_parity;
    logic [5:0] stop_ticks;
    logic par_err_p;
    logic frm_err_p;
    logic par_err_st;
    logic frm_err_st;
  } ulf_top_s;

  ulf_top_s q_ff;
  ulf_top_s nxt_q;
  logic [15:0] divisor;
  logic [15:0] baud_cnt;
  logic baud_tick;
  logic tx_par_bit;
  logic rx_par_exp;
  logic [5:0] stop_len;

  assign divisor = {q_ff.div_hi, q_ff.div_lo};

  ulf_baud_gen u_baud (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .div_i(divisor),
    .load_i(q_ff.div_load),
    .tick_o(baud_tick),
    .cnt_o(baud_cnt)
  );

  ulf_parity u_tx_par (
    .data_i(tx_data_i),
    .len_i(q_ff.len),
    .even_i(q_ff.par_even),
    .stick_i(q_ff.stick),
    .parity_o(tx_par_bit)
  );

  ulf_parity u_rx_par (
    .data_i(rx_data_i),
    .len_i(q_ff.len),
    .even_i(q_ff.par_even),
    .stick_i(q_ff.stick),
    .parity_o(rx_par_exp)
  );

  always_comb begin
    if (!q_ff.stop_sel) begin
      stop_len = ulf_pkg::STOP_ONE_TICKS;
    end else if (q_ff.len == ulf_pkg::LEN_5) begin
      stop_len = ulf_pkg::STOP_HALF_TICKS;
    end else begin
      stop_len = ulf_pkg::STOP_TWO_TICKS;
    end
  end

  assign s_axi_awready_o = !q_ff.aw_got && !q_ff.bvalid;
  assign s_axi_wready_o = !q_ff.w_got && !q_ff.bvalid;
  assign s_axi_arready_o = !q_ff.rvalid;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.div_load = 1'b0;
    nxt_q.par_err_p = 1'b0;
    nxt_q.frm_err_p = 1'b0;
    // Write channels, taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_q.w_got = 1'b1;
      nxt_q.wdata = s_axi_wdata_i[7:0];
      nxt_q.wstrb0 = s_axi_wstrb_i[0];
    end
    if (q_ff.aw_got && q_ff.w_got) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = ulf_pkg::RESP_OKAY;
      case ({q_ff.awaddr[4:2], 2'h0})
        ulf_pkg::OFF_LINE_FMT: begin
          if (q_ff.wstrb0) begin
            nxt_q.len = q_ff.wdata[ulf_pkg::FMT_LEN_LSB +: 2];
            nxt_q.stop_sel = q_ff.wdata[ulf_pkg::FMT_STOP_BIT];
            nxt_q.par_en = q_ff.wdata[ulf_pkg::FMT_PAR_EN_BIT];
            nxt_q.par_even = q_ff.wdata[ulf_pkg::FMT_EVEN_BIT];
            nxt_q.stick = q_ff.wdata[ulf_pkg::FMT_STICK_BIT];
          end
        end
        ulf_pkg::OFF_DIV_LO: begin
          if (q_ff.wstrb0) begin
            nxt_q.div_lo = q_ff.wdata;
            nxt_q.div_load = 1'b1;
          end
        end
        ulf_pkg::OFF_DIV_HI: begin
          if (q_ff.wstrb0) begin
            nxt_q.div_hi = q_ff.wdata;
            nxt_q.div_load = 1'b1;
          end
        end
        ulf_pkg::OFF_STATUS: begin
          // Write one to clear
          if (q_ff.wstrb0 && q_ff.wdata[ulf_pkg::ST_PAR_ERR_BIT]) begin
            nxt_q.par_err_st = 1'b0;
          end
          if (q_ff.wstrb0 && q_ff.wdata[ulf_pkg::ST_FRM_ERR_BIT]) begin
            nxt_q.frm_err_st = 1'b0;
          end
        end
        default: nxt_q.bresp = ulf_pkg::RESP_SLVERR;
      endcase
    end
    if (q_ff.bvalid && s_axi_bready_i) begin
      nxt_q.bvalid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rresp = ulf_pkg::RESP_OKAY;
      nxt_q.rdata = 32'h00000000;
      case ({s_axi_araddr_i[4:2], 2'h0})
        ulf_pkg::OFF_LINE_FMT: nxt_q.rdata[5:0] =
          {q_ff.stick, q_ff.par_even, q_ff.par_en, q_ff.stop_sel, q_ff.len};
        ulf_pkg::OFF_DIV_LO: nxt_q.rdata[7:0] = q_ff.div_lo;
        ulf_pkg::OFF_DIV_HI: nxt_q.rdata[7:0] = q_ff.div_hi;
        ulf_pkg::OFF_STATUS: begin
          nxt_q.rdata[ulf_pkg::ST_PAR_ERR_BIT] = q_ff.par_err_st;
          nxt_q.rdata[ulf_pkg::ST_FRM_ERR_BIT] = q_ff.frm_err_st;
          nxt_q.rdata[ulf_pkg::ST_CNT_LSB +: 16] = baud_cnt;
        end
        default: nxt_q.rresp = ulf_pkg::RESP_SLVERR;
      endcase
    end else if (q_ff.rvalid && s_axi_rready_i) begin
      nxt_q.rvalid = 1'b0;
    end
    // Transmit character framing
    if (tx_load_i) begin
      nxt_q.tx_parity = tx_par_bit;
      nxt_q.stop_ticks = stop_len;
    end
    // Receive checks; first stop bit only
    if (rx_char_valid_i) begin
      nxt_q.par_err_p = q_ff.par_en && (rx_parity_i != rx_par_exp);
      nxt_q.frm_err_p = !rx_stop_i;
    end
    // Event set wins over software clear
    if (nxt_q.par_err_p) begin
      nxt_q.par_err_st = 1'b1;
    end
    if (nxt_q.frm_err_p) begin
      nxt_q.frm_err_st = 1'b1;
    end
    if (!rst_n_i) begin
      nxt_q = '0;
      {nxt_q.stick, nxt_q.par_even, nxt_q.par_en, nxt_q.stop_sel, nxt_q.len} =
        ulf_pkg::FMT_RST;
      nxt_q.div_lo = ulf_pkg::DIV_LO_RST;
      nxt_q.div_hi = ulf_pkg::DIV_HI_RST;
      nxt_q.stop_ticks = ulf_pkg::STOP_ONE_TICKS;
    end
  end

  always_ff @(posedge core_clk_i) begin
    q_ff <= nxt_q;
  end

  assign s_axi_bresp_o = q_ff.bresp;
  assign s_axi_bvalid_o = q_ff.bvalid;
  assign s_axi_rdata_o = q_ff.rdata;
  assign s_axi_rresp_o = q_ff.rresp;
  assign s_axi_rvalid_o = q_ff.rvalid;
  assign tick_16x_o = baud_tick;
  assign char_len_o = q_ff.len;
  assign parity_en_o = q_ff.par_en;
  assign tx_parity_o = q_ff.tx_parity;
  assign tx_stop_ticks_o = q_ff.stop_ticks;
  assign rx_par_err_o = q_ff.par_err_p;
  assign rx_frm_err_o = q_ff.frm_err_p;

  a_stop_one: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_load_i && !q_ff.stop_sel) |=> tx_stop_ticks_o == ulf_pkg::STOP_ONE_TICKS)
    else $error("one stop bit period wrong");
  a_stop_half: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_load_i && q_ff.stop_sel && q_ff.len == ulf_pkg::LEN_5)
      |=> tx_stop_ticks_o == ulf_pkg::STOP_HALF_TICKS)
    else $error("one and a half stop period wrong");
  a_stop_two: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_load_i && q_ff.stop_sel && q_ff.len != ulf_pkg::LEN_5)
      |=> tx_stop_ticks_o == ulf_pkg::STOP_TWO_TICKS)
    else $error("two stop period wrong");
  a_parity_even: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_load_i && q_ff.par_en && !q_ff.stick && q_ff.len == ulf_pkg::LEN_8)
      |=> (^{$past(tx_data_i), tx_parity_o}) == !$past(q_ff.par_even))
    else $error("parity sense wrong");
  a_frame_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_char_valid_i |=> rx_frm_err_o == !$past(rx_stop_i))
    else $error("first stop bit check wrong");
  a_div_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q_ff.aw_got && q_ff.w_got && q_ff.wstrb0 &&
      (q_ff.awaddr[4:2] == 3'h1 || q_ff.awaddr[4:2] == 3'h2))
      |=> q_ff.div_load ##1 baud_cnt == divisor)
    else $error("divisor write did not reload counter");
  a_len_field: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q_ff.aw_got && q_ff.w_got && q_ff.wstrb0 && q_ff.awaddr[4:2] == 3'h0)
      |=> char_len_o == $past(q_ff.wdata[1:0]))
    else $error("length field not applied");
  a_reset_fmt: assert property (@(posedge core_clk_i)
    !rst_n_i |=> divisor == 16'h0000 && char_len_o == ulf_pkg::LEN_5 && !tick_16x_o)
    else $error("format not defined after reset");
  a_err_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rx_par_err_o || rx_frm_err_o) |-> (q_ff.par_err_st || !rx_par_err_o) &&
      (q_ff.frm_err_st || !rx_frm_err_o))
    else $error("error pulse without sticky status");
  a_par_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rx_char_valid_i && !q_ff.par_en) |=> !rx_par_err_o)
    else $error("parity checked while disabled");
  a_reset_stop: assert property (@(posedge core_clk_i)
    !rst_n_i |=> tx_stop_ticks_o == ulf_pkg::STOP_ONE_TICKS && !tx_parity_o)
    else $error("transmit framing not defined after reset");
endmodule : ulf_line_format
`default_nettype wire

// [design/ulf_pkg.sv]
/*
  Package for the line format and baud generator block: register
  offsets, field positions, reset values and stop period lengths.
  Assumes a 32-bit AXI4-Lite register bus with 5-bit byte addresses.
*/
package ulf_pkg;
  localparam int unsigned AXI_AW = 5;
  localparam logic [4:0] OFF_LINE_FMT = 5'h00;
  localparam logic [4:0] OFF_DIV_LO = 5'h04;
  localparam logic [4:0] OFF_DIV_HI = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Line format field positions
  localparam int unsigned FMT_LEN_LSB = 0;
  localparam int unsigned FMT_STOP_BIT = 2;
  localparam int unsigned FMT_PAR_EN_BIT = 3;
  localparam int unsigned FMT_EVEN_BIT = 4;
  localparam int unsigned FMT_STICK_BIT = 5;
  // Status field positions
  localparam int unsigned ST_PAR_ERR_BIT = 0;
  localparam int unsigned ST_FRM_ERR_BIT = 1;
  localparam int unsigned ST_CNT_LSB = 16;
  // Reset values
  localparam logic [5:0] FMT_RST = 6'h00;
  localparam logic [7:0] DIV_LO_RST = 8'h00;
  localparam logic [7:0] DIV_HI_RST = 8'h00;
  // Character length codes
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [1:0] LEN_6 = 2'h1;
  localparam logic [1:0] LEN_7 = 2'h2;
  localparam logic [1:0] LEN_8 = 2'h3;
  // Stop period in 16x ticks
  localparam logic [5:0] STOP_ONE_TICKS = 6'h10;
  localparam logic [5:0] STOP_HALF_TICKS = 6'h18;
  localparam logic [5:0] STOP_TWO_TICKS = 6'h20;
  localparam logic [15:0] DIV_MIN = 16'h0002;
endpackage : ulf_pkg

// [design/ulf_parity.sv]
/*
  Parity bit for one character of 5 to 8 data bits, used for transmit
  generation and receive checking alike.
  Assumes data beyond the selected length may hold any value.
*/
`timescale 1ns/1ps
`default_nettype none
module ulf_parity (
  input wire logic [7:0] data_i,
  input wire logic [1:0] len_i,
  input wire logic even_i,
  input wire logic stick_i,
  output logic parity_o
);
  logic [7:0] mask;
  logic ones_odd;

  always_comb begin
    case (len_i)
      ulf_pkg::LEN_5: mask = 8'h1F;
      ulf_pkg::LEN_6: mask = 8'h3F;
      ulf_pkg::LEN_7: mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
    ones_odd = ^(data_i & mask);
    if (stick_i) begin
      parity_o = ~even_i;
    end else begin
      parity_o = even_i ? ones_odd : ~ones_odd;
    end
  end
endmodule : ulf_parity
`default_nettype wire

// [design/ulf_baud_gen.sv]
/*
  Programmable baud generator: a 16-bit down counter that emits one
  16x tick every div_i clocks.
  Assumes load_i pulses for one cycle after a divisor byte changes.
*/
`timescale 1ns/1ps
`default_nettype none
module ulf_baud_gen (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] div_i,
  input wire logic load_i,
  output logic tick_o,
  output logic [15:0] cnt_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ulf_baud_s;

  ulf_baud_s q_ff;
  ulf_baud_s nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick = 1'b0;
    if (!rst_n_i) begin
      nxt_q = '0;
    end else if (load_i) begin
      nxt_q.cnt = div_i;
    end else if (div_i == 16'h0000) begin
      // Zero divisor: generator stands still
      nxt_q.cnt = 16'h0000;
    end else if (q_ff.cnt <= 16'h0001) begin
      nxt_q.cnt = div_i;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.cnt = q_ff.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    q_ff <= nxt_q;
  end

  assign tick_o = q_ff.tick;
  assign cnt_o = q_ff.cnt;

  a_tick_reload: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick_o |-> cnt_o == $past(div_i))
    else $error("tick without counter reload");
  a_tick_single: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tick_o && div_i >= ulf_pkg::DIV_MIN && $stable(div_i) && !load_i) |=> !tick_o)
    else $error("tick longer than one cycle");
  a_load_counter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    load_i |=> (cnt_o == $past(div_i)) && !tick_o)
    else $error("divisor write did not reload counter");
  a_div_two_rate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tick_o && div_i == 16'h0002 && !load_i) ##1 (!load_i && div_i == 16'h0002) |=> tick_o)
    else $error("divisor two tick rate wrong");
endmodule : ulf_baud_gen
`default_nettype wire

// [tb/ulf_remote_model.sv]
/*
  Far-side character source: hands one received character, its parity
  bit and first stop bit to the receive checks, one cycle per strobe.
  Assumes send_i is a one-cycle pulse driven after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ulf_remote_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  input wire logic par_i,
  input wire logic stop_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic par_o,
  output logic stop_o
);
  logic [9:0] last_ff;
  logic vld_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vld_ff <= 1'h0;
      last_ff <= 10'h000;
    end else begin
      vld_ff <= send_i;
      if (send_i) begin
        last_ff <= {stop_i, par_i, data_i};
      end
    end
  end
  // Outside the strobe the lines show no stale character
  assign valid_o = vld_ff;
  assign {stop_o, par_o, data_o} = vld_ff ? last_ff : ~last_ff;
endmodule : ulf_remote_model
`default_nettype wire

// [tb/ulf_line_format_tb_top.sv]
/*
  Self-checking bench for the line format and baud generator block.
  Assumes the AXI4-Lite map and latencies of the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module ulf_line_format_tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tick, pen, txpar, rv, rp, rs, pe, fe;
  logic [1:0] bresp, rresp, clen;
  logic [31:0] rdata;
  logic txload = 1'h0, send = 1'h0, sp = 1'h0, ss = 1'h0;
  logic [7:0] txd = 8'h00, sd = 8'h00, rd8;
  logic [5:0] stk;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] f;

  always #5 clk = ~clk;

  ulf_line_format dut (
    .core_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .tick_16x_o(tick), .char_len_o(clen), .parity_en_o(pen),
    .tx_load_i(txload), .tx_data_i(txd), .tx_parity_o(txpar), .tx_stop_ticks_o(stk),
    .rx_char_valid_i(rv), .rx_data_i(rd8), .rx_parity_i(rp), .rx_stop_i(rs),
    .rx_par_err_o(pe), .rx_frm_err_o(fe)
  );

  ulf_remote_model far (
    .clk_i(clk), .rst_n_i(rst_n), .send_i(send), .data_i(sd), .par_i(sp),
    .stop_i(ss), .valid_o(rv), .data_o(rd8), .par_o(rp), .stop_o(rs)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      k++;
    end while (bvalid !== 1'h1 && k < 100);
    if (bvalid !== 1'h1) err_total++;
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      k++;
    end while (rvalid !== 1'h1 && k < 100);
    if (rvalid !== 1'h1) err_total++;
    rready <= 1'h0;
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask : rd

  task automatic tx_chk(input logic [7:0] d, input logic ep, input logic [5:0] es);
    txd <= d;
    txload <= 1'h1;
    @(posedge clk);
    txload <= 1'h0;
    @(posedge clk);
    chk({26'h0, stk}, {26'h0, es});
    chk({31'h0, txpar}, {31'h0, ep});
  endtask : tx_chk

  task automatic rx(input logic [7:0] d, input logic p, input logic s, input logic [1:0] ee);
    sd <= d;
    sp <= p;
    ss <= s;
    send <= 1'h1;
    @(posedge clk);
    send <= 1'h0;
    repeat (2) @(posedge clk);
    chk({30'h0, fe, pe}, {30'h0, ee});
  endtask : rx

  task automatic per(input int ex);
    int k;
    k = 0;
    while (tick !== 1'h1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (tick !== 1'h1 && k < 300);
    chk(32'(k), 32'(ex));
  endtask : per

  function automatic logic par_of(input logic [7:0] d, input int l, input logic ev);
    logic p;
    p = ^(d & (8'hFF >> (3 - l)));
    return ev ? p : ~p;
  endfunction : par_of

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk({26'h0, stk}, 32'h10);
    chk({29'h0, clen, pen}, 32'h0);
    rd(ulf_pkg::OFF_LINE_FMT, 32'hFF, 32'h0, ulf_pkg::RESP_OKAY);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (tick === 1'h1) n++;
    end
    chk(32'(n), 32'h0);
    rd(5'h10, 32'hFFFFFFFF, 32'h0, ulf_pkg::RESP_SLVERR);
    wr(5'h14, 8'h01, ulf_pkg::RESP_SLVERR);
    // Every length and stop select, parity on, even select alternating
    for (int l = 0; l < 4; l++) begin
      for (int s = 0; s < 2; s++) begin
        f = {3'h0, 1'(s ^ l), 1'h1, 1'(s), 2'(l)};
        wr(ulf_pkg::OFF_LINE_FMT, f, ulf_pkg::RESP_OKAY);
        rd(ulf_pkg::OFF_LINE_FMT, 32'hFF, {24'h0, f}, ulf_pkg::RESP_OKAY);
        chk({30'h0, clen}, 32'(l));
        chk({31'h0, pen}, 32'h1);
        tx_chk(8'hB6, par_of(8'hB6, l, f[4]), s == 0 ? ulf_pkg::STOP_ONE_TICKS :
               (l == 0 ? ulf_pkg::STOP_HALF_TICKS : ulf_pkg::STOP_TWO_TICKS));
      end
    end
    // Stick parity, odd select: parity bit forced high
    wr(ulf_pkg::OFF_LINE_FMT, 8'h2F, ulf_pkg::RESP_OKAY);
    tx_chk(8'hB6, 1'h1, ulf_pkg::STOP_TWO_TICKS);
    wr(ulf_pkg::OFF_LINE_FMT, 8'h1B, ulf_pkg::RESP_OKAY);
    rx(8'h0F, 1'h0, 1'h1, 2'h0);
    rx(8'h0F, 1'h1, 1'h1, 2'h1);
    rx(8'h0F, 1'h0, 1'h0, 2'h2);
    rd(ulf_pkg::OFF_STATUS, 32'h3, 32'h3, ulf_pkg::RESP_OKAY);
    wr(ulf_pkg::OFF_STATUS, 8'h03, ulf_pkg::RESP_OKAY);
    rd(ulf_pkg::OFF_STATUS, 32'h3, 32'h0, ulf_pkg::RESP_OKAY);
    wr(ulf_pkg::OFF_LINE_FMT, 8'h1F, ulf_pkg::RESP_OKAY);
    rx(8'h0F, 1'h0, 1'h1, 2'h0);
    // Parity disabled: parity bit correct for odd select raises no error
    wr(ulf_pkg::OFF_LINE_FMT, 8'h03, ulf_pkg::RESP_OKAY);
    rx(8'h0F, 1'h1, 1'h1, 2'h0);
    // Baud generator: both bytes written before use, low byte first so never zero
    wr(ulf_pkg::OFF_DIV_LO, 8'h05, ulf_pkg::RESP_OKAY);
    wr(ulf_pkg::OFF_DIV_HI, 8'h00, ulf_pkg::RESP_OKAY);
    rd(ulf_pkg::OFF_DIV_LO, 32'hFF, 32'h5, ulf_pkg::RESP_OKAY);
    per(5);
    wr(ulf_pkg::OFF_DIV_LO, 8'h02, ulf_pkg::RESP_OKAY);
    per(2);
    wr(ulf_pkg::OFF_DIV_HI, 8'h01, ulf_pkg::RESP_OKAY);
    per(258);
    repeat (20) @(posedge clk);
    wr(ulf_pkg::OFF_DIV_HI, 8'h00, ulf_pkg::RESP_OKAY);
    n = 0;
    while (tick !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n <= 6), 32'h1);
    per(2);
    wr(ulf_pkg::OFF_DIV_LO, 8'h18, ulf_pkg::RESP_OKAY);
    per(24);
    // Reset in mid-run restores format, framing and divisor
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk({25'h0, txpar, stk}, 32'h10);
    chk({29'h0, clen, pen}, 32'h0);
    rd(ulf_pkg::OFF_LINE_FMT, 32'hFF, 32'h0, ulf_pkg::RESP_OKAY);
    rd(ulf_pkg::OFF_DIV_LO, 32'hFF, 32'h0, ulf_pkg::RESP_OKAY);
    rd(ulf_pkg::OFF_DIV_HI, 32'hFF, 32'h0, ulf_pkg::RESP_OKAY);
    end_sim();
  end
endmodule : ulf_line_format_tb_top
`default_nettype wire
